// ===== inc/pll_status_pkg.sv
// Constants, types and field layout of the loop status register pair.
package pll_status_pkg;

   localparam logic [7:0] INT_HIGH_OFS = 8'h08;
   localparam logic [7:0] OPSTAT_OFS = 8'h09;
   // Only bit 7 of this pattern has storage behind it; the other bits read as zero.
   localparam logic [7:0] INT_HIGH_RST = 8'h10;
   localparam logic [7:0] OPSTAT_RST = 8'h01;
   localparam logic [7:0] UNMAPPED_DATA = 8'h00;

   localparam int INT_SYNC_BIT = 7;
   localparam int OPS_SYNC_BIT = 7;
   localparam int OPS_LOCK_BIT = 6;
   localparam int OPS_MAIN_WARN_BIT = 5;
   localparam int OPS_SECOND_WARN_BIT = 4;

   typedef enum logic [2:0] {
      ST_UNUSED_0 = 3'h0,
      ST_FREE_RUN = 3'h1,
      ST_HOLDOVER = 3'h2,
      ST_UNUSED_3 = 3'h3,
      ST_LOCKED = 3'h4,
      ST_PRE_LOCKED2 = 3'h5,
      ST_PRE_LOCKED = 3'h6,
      ST_PHASE_LOST = 3'h7
   } main_loop_state_e;

   localparam main_loop_state_e MAIN_STATE_RST = ST_FREE_RUN;

   typedef struct packed {
      logic fine;
      logic coarse;
      logic no_activity;
      logic freq_limit;
   } phase_loss_s;

   typedef struct packed {
      logic fine;
      logic coarse;
      logic no_activity;
      logic freq_limit;
   } loss_enable_s;

   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } reg_req_s;

endpackage

// ===== rtl/second_loop_lock.sv
// Lock indication of the second phase loop built from its phase-loss indicators.
`timescale 1ns/100ps
module second_loop_lock
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire pll_status_pkg::phase_loss_s loss_i,
   input wire pll_status_pkg::loss_enable_s enable_i,
   output logic locked_o
);

   logic coarse_latch_r;
   logic coarse_latch_nxt;
   logic locked_r;
   logic locked_nxt;

   always_comb
   begin
      // A slip in the same cycle as the enable is set wins over the stale clear.
      coarse_latch_nxt = enable_i.coarse & (coarse_latch_r | loss_i.coarse);
      locked_nxt = ~((enable_i.fine & loss_i.fine)
                     | (enable_i.no_activity & loss_i.no_activity)
                     | (enable_i.freq_limit & loss_i.freq_limit)
                     | coarse_latch_nxt);
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         coarse_latch_r <= 1'b0;
         locked_r <= 1'b0;
      end
      else
      begin
         coarse_latch_r <= coarse_latch_nxt;
         locked_r <= locked_nxt;
      end
   end

   assign locked_o = locked_r;

   a_slip_unlocks: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      enable_i.coarse && loss_i.coarse |=> !locked_o)
      else $error("coarse slip did not clear the lock bit");

   a_latch_stays_low: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      coarse_latch_r && enable_i.coarse |=> coarse_latch_r && !locked_o)
      else $error("latched coarse loss was lost while enabled");

   a_enabled_loss_unlocks: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (enable_i.fine && loss_i.fine) || (enable_i.freq_limit && loss_i.freq_limit)
      || (enable_i.no_activity && loss_i.no_activity) |=> !locked_o)
      else $error("enabled phase loss left the lock bit set");

   a_clean_locks: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !enable_i.coarse && !(enable_i.fine && loss_i.fine) && !(enable_i.freq_limit && loss_i.freq_limit)
      && !(enable_i.no_activity && loss_i.no_activity) |=> locked_o && !coarse_latch_r)
      else $error("lock bit low with no enabled loss");

endmodule // second_loop_lock

// ===== rtl/pll_status_alarm_regs.sv
// Interrupt byte and operating status register of the phase loop protection block.
`timescale 1ns/100ps
module pll_status_alarm_regs
(
   input wire logic MCLK_I,
   input wire logic RST_N_I,
   input wire pll_status_pkg::reg_req_s REG_REQ_I,
   output logic [7:0] REG_RDATA_O,
   input wire logic SYNC_ALARM_EVENT_I,
   input wire logic SYNC_ALARM_LIVE_I,
   input wire pll_status_pkg::phase_loss_s SECOND_LOSS_I,
   input wire pll_status_pkg::loss_enable_s LOSS_ENABLE_I,
   input wire logic MAIN_FREQ_WARN_I,
   input wire logic SECOND_FREQ_WARN_I,
   input wire logic [2:0] MAIN_STATE_I
);

   logic sync_int_r;
   logic sync_int_nxt;
   logic sync_live_r;
   logic sync_live_nxt;
   logic main_warn_r;
   logic main_warn_nxt;
   logic second_warn_r;
   logic second_warn_nxt;
   pll_status_pkg::main_loop_state_e main_state_r;
   pll_status_pkg::main_loop_state_e main_state_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic second_loop_locked;
   logic int_clear;
   logic [7:0] int_view;
   logic [7:0] opstat_view;

   second_loop_lock u_lock
   (
      .clk_i(MCLK_I),
      .rst_n_i(RST_N_I),
      .loss_i(SECOND_LOSS_I),
      .enable_i(LOSS_ENABLE_I),
      .locked_o(second_loop_locked)
   );

   // Register views; bits without a function are tied low and never stored.
   always_comb
   begin
      int_view = 8'h00;
      int_view[pll_status_pkg::INT_SYNC_BIT] = sync_int_r;
      opstat_view = 8'h00;
      opstat_view[pll_status_pkg::OPS_SYNC_BIT] = sync_live_r;
      opstat_view[pll_status_pkg::OPS_LOCK_BIT] = second_loop_locked;
      opstat_view[pll_status_pkg::OPS_MAIN_WARN_BIT] = main_warn_r;
      opstat_view[pll_status_pkg::OPS_SECOND_WARN_BIT] = second_warn_r;
      opstat_view[2:0] = main_state_r;
   end

   always_comb
   begin
      int_clear = REG_REQ_I.wr && (REG_REQ_I.addr == pll_status_pkg::INT_HIGH_OFS)
                  && REG_REQ_I.wdata[pll_status_pkg::INT_SYNC_BIT];
      // A new alarm in the clearing cycle is kept, so no event is lost.
      sync_int_nxt = SYNC_ALARM_EVENT_I | (sync_int_r & ~int_clear);
      sync_live_nxt = SYNC_ALARM_LIVE_I;
      main_warn_nxt = MAIN_FREQ_WARN_I;
      second_warn_nxt = SECOND_FREQ_WARN_I;
      // Unused codes from the loop are not stored, so software never sees them.
      case (MAIN_STATE_I)
         pll_status_pkg::ST_FREE_RUN,
         pll_status_pkg::ST_HOLDOVER,
         pll_status_pkg::ST_LOCKED,
         pll_status_pkg::ST_PRE_LOCKED2,
         pll_status_pkg::ST_PRE_LOCKED,
         pll_status_pkg::ST_PHASE_LOST:
            main_state_nxt = pll_status_pkg::main_loop_state_e'(MAIN_STATE_I);
         default:
            main_state_nxt = main_state_r;
      endcase
   end

   // Reads have no side effect; the operating status ignores all writes.
   always_comb
   begin
      rdata_nxt = rdata_r;
      if (REG_REQ_I.rd)
      begin
         case (REG_REQ_I.addr)
            pll_status_pkg::INT_HIGH_OFS:
               rdata_nxt = int_view;
            pll_status_pkg::OPSTAT_OFS:
               rdata_nxt = opstat_view;
            default:
               rdata_nxt = pll_status_pkg::UNMAPPED_DATA;
         endcase
      end
   end

   always_ff @(posedge MCLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         sync_int_r <= pll_status_pkg::INT_HIGH_RST[pll_status_pkg::INT_SYNC_BIT];
         sync_live_r <= pll_status_pkg::OPSTAT_RST[pll_status_pkg::OPS_SYNC_BIT];
         main_warn_r <= pll_status_pkg::OPSTAT_RST[pll_status_pkg::OPS_MAIN_WARN_BIT];
         second_warn_r <= pll_status_pkg::OPSTAT_RST[pll_status_pkg::OPS_SECOND_WARN_BIT];
         main_state_r <= pll_status_pkg::MAIN_STATE_RST;
         rdata_r <= 8'h00;
      end
      else
      begin
         sync_int_r <= sync_int_nxt;
         sync_live_r <= sync_live_nxt;
         main_warn_r <= main_warn_nxt;
         second_warn_r <= second_warn_nxt;
         main_state_r <= main_state_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign REG_RDATA_O = rdata_r;

   a_int_sets: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      SYNC_ALARM_EVENT_I |=> sync_int_r)
      else $error("sync alarm event did not latch");

   a_int_holds: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      sync_int_r && !(REG_REQ_I.wr && REG_REQ_I.addr == pll_status_pkg::INT_HIGH_OFS) |=> sync_int_r)
      else $error("sync alarm interrupt dropped without a write");

   a_int_w1c: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      int_clear && !SYNC_ALARM_EVENT_I |=> !sync_int_r)
      else $error("write of one did not clear the interrupt");

   a_int_read: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      REG_REQ_I.rd && REG_REQ_I.addr == pll_status_pkg::INT_HIGH_OFS
      |=> REG_RDATA_O == {$past(sync_int_r), 7'h00})
      else $error("interrupt byte read returned wrong data");

   a_opstat_read: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      REG_REQ_I.rd && REG_REQ_I.addr == pll_status_pkg::OPSTAT_OFS
      |=> REG_RDATA_O[7] == $past(sync_live_r) && REG_RDATA_O[3] == 1'b0
          && REG_RDATA_O[2:0] == $past(main_state_r))
      else $error("operating status read returned wrong data");

   a_live_alarm: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      SYNC_ALARM_LIVE_I ##1 (REG_REQ_I.rd && REG_REQ_I.addr == pll_status_pkg::OPSTAT_OFS)
      |=> REG_RDATA_O[pll_status_pkg::OPS_SYNC_BIT])
      else $error("live sync alarm not reported");

   a_warn_bits: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      ##1 (REG_REQ_I.rd && REG_REQ_I.addr == pll_status_pkg::OPSTAT_OFS)
      |=> REG_RDATA_O[5] == $past(MAIN_FREQ_WARN_I, 2) && REG_RDATA_O[4] == $past(SECOND_FREQ_WARN_I, 2))
      else $error("frequency warning bits wrong");

   a_state_legal: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      main_state_r != pll_status_pkg::ST_UNUSED_0 && main_state_r != pll_status_pkg::ST_UNUSED_3)
      else $error("main loop state holds an unused code");

   a_state_tracks: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      MAIN_STATE_I == 3'h4 |=> main_state_r == pll_status_pkg::ST_LOCKED)
      else $error("main loop state not captured");

   a_unmapped_zero: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      REG_REQ_I.rd && REG_REQ_I.addr != pll_status_pkg::OPSTAT_OFS
      && REG_REQ_I.addr != pll_status_pkg::INT_HIGH_OFS |=> REG_RDATA_O == 8'h00)
      else $error("unmapped read not zero");

   a_rdata_holds: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      !REG_REQ_I.rd |=> $stable(REG_RDATA_O))
      else $error("read data changed without a read");

endmodule // pll_status_alarm_regs

// ===== verif/pll_status_alarm_regs_bench.sv
// Self-checking bench for the interrupt byte and operating status register pair.
`timescale 1ns/100ps
`define CHK(got, exp) \
   begin \
      cmp_count++; \
      if ((got) !== (exp)) \
      begin \
         errors++; \
         $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
      end \
   end
module pll_status_alarm_regs_bench;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   pll_status_pkg::reg_req_s req = '0;
   logic [7:0] rdata;
   logic ev = 1'b0;
   logic live = 1'b0;
   pll_status_pkg::phase_loss_s loss = 4'h8;
   pll_status_pkg::loss_enable_s en = 4'hf;
   logic w1 = 1'b0;
   logic w2 = 1'b0;
   // An unused code at reset release shows that the reset state is kept, not copied from the input.
   logic [2:0] st = 3'h0;
   logic [2:0] codes [6] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
   int errors = 0;
   int cmp_count = 0;

   always #20 mclk = ~mclk;

   pll_status_alarm_regs DUT
   (
      .MCLK_I(mclk),
      .RST_N_I(rst_n),
      .REG_REQ_I(req),
      .REG_RDATA_O(rdata),
      .SYNC_ALARM_EVENT_I(ev),
      .SYNC_ALARM_LIVE_I(live),
      .SECOND_LOSS_I(loss),
      .LOSS_ENABLE_I(en),
      .MAIN_FREQ_WARN_I(w1),
      .SECOND_FREQ_WARN_I(w2),
      .MAIN_STATE_I(st)
   );

   task automatic tick(input int n);
      repeat (n) @(negedge mclk);
   endtask

   // Status inputs are set at a falling edge before the call, so one rising edge registers them first.
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge mclk);
      req.addr = a;
      req.rd = 1'b1;
      @(negedge mclk);
      req.rd = 1'b0;
      `CHK(rdata, e)
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      req.addr = a;
      req.wdata = d;
      req.wr = 1'b1;
      @(negedge mclk);
      req.wr = 1'b0;
   endtask

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial
   begin
      repeat (20) @(negedge mclk);
      rst_n = 1'b1;
      rd(8'h09, 8'h01);
      rd(8'h08, 8'h00);
      wr(8'h09, 8'hff);
      rd(8'h09, 8'h01);
      rd(8'h0a, 8'h00);
      ev = 1'b1;
      tick(1);
      ev = 1'b0;
      tick(2);
      rd(8'h08, 8'h80);
      wr(8'h08, 8'h7f);
      rd(8'h08, 8'h80);
      wr(8'h08, 8'h80);
      rd(8'h08, 8'h00);
      // An alarm in the same cycle as the clearing write must survive.
      @(negedge mclk);
      req.addr = 8'h08;
      req.wdata = 8'h80;
      req.wr = 1'b1;
      ev = 1'b1;
      tick(1);
      req.wr = 1'b0;
      ev = 1'b0;
      rd(8'h08, 8'h80);
      live = 1'b1;
      w1 = 1'b1;
      rd(8'h09, 8'ha1);
      live = 1'b0;
      w1 = 1'b0;
      w2 = 1'b1;
      rd(8'h09, 8'h11);
      w2 = 1'b0;
      foreach (codes[i])
      begin
         st = codes[i];
         rd(8'h09, {5'h00, codes[i]});
      end
      // Unused codes must leave the last real state visible.
      st = 3'h3;
      rd(8'h09, 8'h07);
      st = 3'h0;
      rd(8'h09, 8'h07);
      st = 3'h4;
      loss = 4'h0;
      tick(2);
      rd(8'h09, 8'h44);
      for (int i = 0; i < 4; i++)
      begin
         loss = 4'(4'h1 << i);
         tick(2);
         rd(8'h09, 8'h04);
         en = ~loss;
         tick(2);
         rd(8'h09, 8'h44);
         loss = 4'h0;
         en = 4'hf;
         tick(2);
      end
      // A single cycle slip must hold the lock bit low after it has gone.
      loss.coarse = 1'b1;
      tick(1);
      loss.coarse = 1'b0;
      tick(3);
      rd(8'h09, 8'h04);
      en.coarse = 1'b0;
      tick(2);
      rd(8'h09, 8'h44);
      en.coarse = 1'b1;
      tick(2);
      rd(8'h09, 8'h44);
      // A reset in mid-run must restore the defaults while the inputs show other values.
      st = 3'h3;
      rst_n = 1'b0;
      tick(2);
      rst_n = 1'b1;
      rd(8'h09, 8'h41);
      rd(8'h08, 8'h00);
      complete_run();
   end

   // The sequence needs about 130 cycles, so this limit only trips on a hang.
   initial
   begin
      repeat (2000) @(posedge mclk);
      errors++;
      complete_run();
   end
endmodule // pll_status_alarm_regs_bench
